/* File: rtl/ldo_regulator_control_pkg.sv */
// types of the regulator control bank
package ldo_regulator_control_pkg;
	typedef struct packed {
		logic [1:0] undervoltage_action;
		logic rsv13;
		logic [1:0] hw_control_source;
		logic hw_control_voltage_pick;
		logic [1:0] hw_control_op_mode;
		logic output_float_when_off;
		logic switch_mode_select;
		logic [4:0] rsv1;
		logic low_power_class;
	} ctrl_reg_t;
	typedef struct packed {
		logic [2:0] start_slot_select;
		logic [3:0] rsv9;
		logic on_state_op_mode;
		logic [2:0] rsv5;
		logic [4:0] on_state_voltage_code;
	} on_reg_t;
	typedef struct packed {
		logic enable;
		logic discharge;
		logic switch_mode;
		logic low_power;
		logic low_power_class;
		logic [4:0] voltage_code;
		logic [11:0] target_mv;
	} ldo_ctl_t;
	typedef enum logic [2:0] {
		PWR_OFF = 3'b001,
		PWR_ON = 3'b010,
		PWR_TRIP = 3'b100
	} pwr_state_t;
endpackage

/* File: rtl/ldo_regulator_control_regs.sv */
// control registers and output steering of the first linear regulator
// Contract
// - undervoltage action 00 ignore, 01 regulator off, 10 system reset, 11 reserved.
// - every undervoltage fault raises an interrupt whatever the action setting.
// - hardware control source 00 none, 01 input one, 10 input two, 11 either.
// - under hardware control voltage pick 0 uses on code, 1 sleep code.
// - hardware mode 00/10 low power, 01 off, 11 follows on-state mode bit.
// - float bit 0 discharges output when off; separate bit selects switch mode.
// - low-power class bit picks 50mA class (0) or 20mA class (1).
// - start slot 000 never, 001-101 timeslots 1-5, 110/111 hardware enables.
// - on-state mode bit 0 normal, 1 low power.
// - codes 00h-0Eh 0.90-1.60V by 50mV, 0Fh-1Fh 1.70-3.30V by 100mV.
// - sleep voltage code uses the same five-bit encoding as on code.
`timescale 1ns/10ps
`include "ldo_regulator_control_regs.svh"
module ldo_regulator_control_regs
	import ldo_regulator_control_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins, asynchronous
	input wire logic [1:0] hw_control_in,
	input wire logic [1:0] hw_enable_in,
	input wire logic undervoltage_in,
	// sequencer and sleep register, same clock
	input wire logic [4:0] timeslot_strobe,
	input wire logic [4:0] sleep_state_voltage_code,
	// regulator side
	output ldo_ctl_t ldo_ctl,
	output logic uv_interrupt,
	output logic system_reset_req
);
	ctrl_reg_t ctrl_q;
	on_reg_t on_q;
	ldo_ctl_t ctl_d;
	ldo_ctl_t ctl_q;
	pwr_state_t state_q;
	pwr_state_t state_d;
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic uv_prev_q;
	logic irq_q;
	logic sysrst_q;
	logic [31:0] rdata_q;

	// two flops before any logic looks at the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end else begin
			sync1_q <= {undervoltage_in, hw_enable_in, hw_control_in};
			sync2_q <= sync1_q;
		end
	end

	wire [1:0] hwc_s = sync2_q[1:0];
	wire [1:0] hwen_s = sync2_q[3:2];
	wire uv_s = sync2_q[4];
	wire uv_rise = uv_s && !uv_prev_q;

	// apb decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_ctrl = (paddr == `CTRL_ADDR);
	wire hit_on = (paddr == `ON_ADDR);
	wire hit_stat = (paddr == `STATUS_ADDR);
	wire mapped = hit_ctrl || hit_on || hit_stat;
	wire wr_ctrl = access && pwrite && hit_ctrl;
	wire wr_on = access && pwrite && hit_on;
	assign pready = 1'b1;
	// status is read-only, so a write there is refused too
	assign pslverr = access && (!mapped || (pwrite && hit_stat));
	assign prdata = rdata_q;

	wire [15:0] status_word = {state_q, 1'b0, uv_s, hwen_s, hwc_s, ctl_q.enable,
		ctl_q.low_power, ctl_q.voltage_code};
	wire [15:0] rd_sel = hit_ctrl ? (ctrl_q & `CTRL_MASK) :
		hit_on ? (on_q & `ON_MASK) :
		hit_stat ? status_word : 16'h0000;

	// read data captured in setup so it comes from a flop in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h00000000;
		end else if (setup && !pwrite) begin
			rdata_q <= {16'h0000, rd_sel};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RESET;
			on_q <= `ON_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata[15:0] & `CTRL_MASK;
			end
			if (wr_on) begin
				on_q <= pwdata[15:0] & `ON_MASK;
			end
		end
	end

	// hardware control selection
	wire hwc_active = (ctrl_q.hw_control_source == `HWC_IN1) ? hwc_s[0] :
		(ctrl_q.hw_control_source == `HWC_IN2) ? hwc_s[1] :
		(ctrl_q.hw_control_source == `HWC_NONE) ? 1'b0 : |hwc_s;
	wire hwc_off = hwc_active && (ctrl_q.hw_control_op_mode == `HWC_OFF);
	wire hwc_lp = (ctrl_q.hw_control_op_mode == `HWC_FROM_ON) ?
		on_q.on_state_op_mode : 1'b1;

	// start slot: timeslots latch on, hardware enables follow their level
	wire [2:0] slot = on_q.start_slot_select;
	wire slot_seq = (slot != `SLOT_NEVER) && (slot <= `SLOT_LAST);
	wire [2:0] slot_idx = slot - 3'h1;
	wire slot_hit = slot_seq && timeslot_strobe[slot_idx];
	wire hwen_on = (slot == `SLOT_HWEN1) ? hwen_s[0] :
		(slot == `SLOT_HWEN2) ? hwen_s[1] : 1'b0;
	wire trip_req = uv_rise && (ctrl_q.undervoltage_action == `UV_SHUT_REG);

	always_comb begin
		state_d = state_q;
		case (state_q)
			PWR_OFF: begin
				if (trip_req) begin
					state_d = PWR_TRIP;
				end else if (slot_hit || hwen_on) begin
					state_d = PWR_ON;
				end
			end
			PWR_ON: begin
				if (trip_req) begin
					state_d = PWR_TRIP;
				end else if (slot == `SLOT_NEVER || (!slot_seq && !hwen_on)) begin
					state_d = PWR_OFF;
				end
			end
			PWR_TRIP: begin
				// stays off until software rewrites the control register
				if (wr_ctrl) begin
					state_d = PWR_OFF;
				end
			end
			default: begin
				state_d = PWR_OFF;
			end
		endcase
	end

	// output voltage and mode
	wire [4:0] vcode = (hwc_active && ctrl_q.hw_control_voltage_pick) ?
		sleep_state_voltage_code : on_q.on_state_voltage_code;
	wire lp_now = hwc_active ? hwc_lp : on_q.on_state_op_mode;
	wire en_now = (state_q == PWR_ON) && !hwc_off;
	wire fine = (vcode <= `CODE_FINE_LAST);
	wire [11:0] code12 = {7'h00, vcode};
	wire [11:0] mv_fine = `MV_BASE_FINE + 12'(code12 * `MV_STEP_FINE);
	wire [11:0] mv_coarse = `MV_BASE_COARSE +
		12'((code12 - 12'h00f) * `MV_STEP_COARSE);

	always_comb begin
		ctl_d.enable = en_now;
		ctl_d.discharge = !en_now && !ctrl_q.output_float_when_off;
		ctl_d.switch_mode = ctrl_q.switch_mode_select;
		ctl_d.low_power = lp_now;
		ctl_d.low_power_class = ctrl_q.low_power_class;
		ctl_d.voltage_code = vcode;
		ctl_d.target_mv = fine ? mv_fine : mv_coarse;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PWR_OFF;
			ctl_q <= '0;
			uv_prev_q <= 1'b0;
			irq_q <= 1'b0;
			sysrst_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ctl_q <= ctl_d;
			uv_prev_q <= uv_s;
			irq_q <= uv_rise;
			sysrst_q <= uv_rise && (ctrl_q.undervoltage_action == `UV_SHUT_SYS);
		end
	end

	assign ldo_ctl = ctl_q;
	assign uv_interrupt = irq_q;
	assign system_reset_req = sysrst_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence uv_edge_s;
		uv_rise;
	endsequence
	sequence wr_on_s;
		wr_on && !hwc_active && slot == `SLOT_NEVER;
	endsequence

	uv_ignore_a: assert property (uv_edge_s and (ctrl_q.undervoltage_action == `UV_IGNORE)
		|=> !system_reset_req && state_q != PWR_TRIP)
		else $error("ignored fault acted");
	uv_sysreset_a: assert property (uv_edge_s and (ctrl_q.undervoltage_action == `UV_SHUT_SYS)
		|=> system_reset_req)
		else $error("system reset not requested");
	uv_irq_a: assert property (uv_edge_s |=> uv_interrupt)
		else $error("fault without interrupt");
	hwc_off_a: assert property (hwc_off |=> !ldo_ctl.enable)
		else $error("hardware off mode left regulator on");
	hwc_src_a: assert property ((ctrl_q.hw_control_source == `HWC_NONE)
		&& ctrl_q.hw_control_voltage_pick |=> ldo_ctl.voltage_code == $past(on_q.on_state_voltage_code))
		else $error("source none still used hardware control");
	vpick_a: assert property (hwc_active && ctrl_q.hw_control_voltage_pick
		|=> ldo_ctl.voltage_code == $past(sleep_state_voltage_code))
		else $error("sleep code not selected");
	discharge_a: assert property (ldo_ctl.discharge |-> !ldo_ctl.enable)
		else $error("discharge while enabled");
	lp_class_a: assert property (##1 ldo_ctl.low_power_class == $past(ctrl_q.low_power_class))
		else $error("low power class wrong");
	slot_never_a: assert property (slot == `SLOT_NEVER && !trip_req |=> ##1 !ldo_ctl.enable)
		else $error("slot never but enabled");
	on_mode_a: assert property (!hwc_active |=> ldo_ctl.low_power == $past(on_q.on_state_op_mode))
		else $error("on mode not applied");
	mv_map_a: assert property (ldo_ctl.voltage_code == 5'h0f |-> ldo_ctl.target_mv == 12'h6a4)
		else $error("voltage map wrong");
	wr_latency_a: assert property (wr_on_s ##1 !wr_on && !hwc_active
		|=> ldo_ctl.voltage_code == $past(pwdata[4:0], 2))
		else $error("write did not reach output");
endmodule // ldo_regulator_control_regs

/* File: rtl/ldo_regulator_control_regs.svh */
// register indices, masks, reset values and field codes of the regulator bank
`ifndef LDO_REGULATOR_CONTROL_REGS_SVH
`define LDO_REGULATOR_CONTROL_REGS_SVH
`define CTRL_INDEX 16'h4068
`define ON_INDEX 16'h4069
`define STATUS_INDEX 16'h4080
`define CTRL_ADDR {2'h0, `CTRL_INDEX, 2'h0}
`define ON_ADDR {2'h0, `ON_INDEX, 2'h0}
`define STATUS_ADDR {2'h0, `STATUS_INDEX, 2'h0}
`define CTRL_MASK 16'hdfc1
`define ON_MASK 16'he11f
`define CTRL_RESET 16'h0200
`define ON_RESET 16'h0000
`define UV_IGNORE 2'h0
`define UV_SHUT_REG 2'h1
`define UV_SHUT_SYS 2'h2
`define HWC_NONE 2'h0
`define HWC_IN1 2'h1
`define HWC_IN2 2'h2
`define HWC_OFF 2'h1
`define HWC_FROM_ON 2'h3
`define SLOT_NEVER 3'h0
`define SLOT_LAST 3'h5
`define SLOT_HWEN1 3'h6
`define SLOT_HWEN2 3'h7
`define CODE_FINE_LAST 5'h0e
`define MV_BASE_FINE 12'h384
`define MV_BASE_COARSE 12'h6a4
`define MV_STEP_FINE 12'h032
`define MV_STEP_COARSE 12'h064
`endif

/* File: sim/ldo_regulator_control_regs_tb_top.sv */
// self-checking bench for the regulator control register bank
`timescale 1ns/10ps
`include "ldo_regulator_control_regs.svh"
module ldo_regulator_control_regs_tb_top;
	import ldo_regulator_control_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [19:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, uv_interrupt, system_reset_req;
	logic [1:0] hwc = '0, hwe = '0;
	logic uv = 1'b0;
	logic [4:0] strobe = '0, slp = 5'h1a;
	ldo_ctl_t ldo_ctl;
	int error_cnt = 0, n_checks = 0, ints, rsts;
	logic [15:0] ctrl_m, on_m;
	logic slot_on = 1'b0, trip = 1'b0;
	always #4 pclk = ~pclk;
	ldo_regulator_control_regs ldo_regulator_control_regs_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_control_in(hwc),
		.hw_enable_in(hwe), .undervoltage_in(uv), .timeslot_strobe(strobe),
		.sleep_state_voltage_code(slp), .ldo_ctl(ldo_ctl), .uv_interrupt(uv_interrupt),
		.system_reset_req(system_reset_req));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one apb transfer; waits on pready, never on a fixed count
	task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		check("pready", {31'h0, pready}, 32'h1);
		if (pready === 1'b1) check("pslverr", {31'h0, pslverr}, {31'h0, a != `CTRL_ADDR && a != `ON_ADDR && (a != `STATUS_ADDR || wr)});
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr_ctrl(input logic [15:0] v);
		ctrl_m = v & `CTRL_MASK;
		trip = 1'b0;
		apb(1'b1, `CTRL_ADDR, {16'h0, v});
	endtask
	task automatic wr_on(input logic [15:0] v);
		on_m = v & `ON_MASK;
		if (on_m[15:13] == 3'h0) slot_on = 1'b0;
		apb(1'b1, `ON_ADDR, {16'h0, v});
	endtask
	function automatic int mv(input int c);
		return c <= 14 ? 900 + 50 * c : 1700 + 100 * (c - 15);
	endfunction
	// behavioural model of the output steering, compared after pin latency has passed
	task automatic out_chk();
		logic act, en, lp;
		logic [4:0] code;
		logic [2:0] s;
		repeat (5) @(posedge pclk);
		#1;
		s = on_m[15:13];
		act = (ctrl_m[12:11] == 2'h1 && hwc[0]) || (ctrl_m[12:11] == 2'h2 && hwc[1])
			|| (ctrl_m[12:11] == 2'h3 && |hwc);
		en = (s == 3'h6 ? hwe[0] : s == 3'h7 ? hwe[1] : slot_on) && !trip
			&& !(act && ctrl_m[9:8] == `HWC_OFF);
		lp = act && ctrl_m[9:8] != `HWC_FROM_ON ? 1'b1 : on_m[8];
		code = act && ctrl_m[10] ? slp : on_m[4:0];
		check("enable", {31'h0, ldo_ctl.enable}, {31'h0, en});
		check("discharge", {31'h0, ldo_ctl.discharge}, {31'h0, !en && !ctrl_m[7]});
		check("switch", {31'h0, ldo_ctl.switch_mode}, {31'h0, ctrl_m[6]});
		check("lp_class", {31'h0, ldo_ctl.low_power_class}, {31'h0, ctrl_m[0]});
		if (en) begin
			check("low_power", {31'h0, ldo_ctl.low_power}, {31'h0, lp});
			check("code", {27'h0, ldo_ctl.voltage_code}, {27'h0, code});
			check("target_mv", {20'h0, ldo_ctl.target_mv}, mv(int'(code)));
		end
	endtask
	initial begin
		#400000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h319e));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `CTRL_ADDR, 32'h0);
		check("ctrl_reset", rd, {16'h0, `CTRL_RESET});
		apb(1'b0, `ON_ADDR, 32'h0);
		check("on_reset", rd, {16'h0, `ON_RESET});
		apb(1'b0, 20'h00010, 32'h0);
		check("unmapped", rd, 32'h0);
		apb(1'b0, `STATUS_ADDR, 32'h0);
		check("status_reset", rd, 32'h00002000);
		apb(1'b1, `STATUS_ADDR, 32'hffff);
		apb(1'b0, `CTRL_ADDR, 32'h0);
		check("ctrl_after_refused", rd, {16'h0, `CTRL_RESET});
		for (int i = 0; i < 8; i++) begin
			wr_ctrl($urandom() & 16'h3fff);
			apb(1'b0, `CTRL_ADDR, 32'h0);
			check("ctrl_rb", rd, {16'h0, ctrl_m});
			wr_on($urandom());
			apb(1'b0, `ON_ADDR, 32'h0);
			check("on_rb", rd, {16'h0, on_m});
		end
		wr_ctrl(16'h0);
		hwe <= 2'h1;
		for (int c = 0; c < 32; c++) begin
			wr_on({3'h6, 4'h0, 1'($urandom()), 3'h0, 5'(c)});
			out_chk();
		end
		wr_on(16'he005);
		hwe <= 2'h2;
		for (int i = 0; i < 32; i++) begin
			hwc <= 2'($urandom());
			wr_ctrl({3'h0, 2'(i >> 3), i[0], 2'(i >> 1), 1'($urandom()), 1'($urandom()),
				5'h0, 1'($urandom())});
			out_chk();
		end
		hwc <= 2'h0;
		hwe <= 2'h0;
		for (int k = 1; k <= 5; k++) begin
			wr_on({3'(k), 13'h0003});
			strobe <= 5'h1 << (k % 5);
			@(posedge pclk) strobe <= 5'h0;
			out_chk();
			strobe <= 5'h1 << (k - 1);
			slot_on = 1'b1;
			@(posedge pclk) strobe <= 5'h0;
			out_chk();
			wr_on(16'h0003);
			out_chk();
		end
		wr_on(16'hc007);
		hwe <= 2'h1;
		for (int a = 0; a < 4; a++) begin
			wr_ctrl({2'(a), 14'h0});
			ints = 0;
			rsts = 0;
			uv <= 1'b1;
			repeat (6) begin
				@(posedge pclk);
				#1;
				ints += uv_interrupt;
				rsts += system_reset_req;
			end
			check("interrupts", ints, 1);
			check("sys_reset", rsts, a == 2);
			trip = (a == 1);
			out_chk();
			uv <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		print_verdict();
	end
endmodule // ldo_regulator_control_regs_tb_top
